/* File: spmf_fifo.v */
// Four-byte first-in first-out queue whose read data come out of a register.
module spmf_fifo (
   input wire clk_in,
   input wire rstn_in,
   input wire clr_in,
   input wire push_in,
   input wire [7:0] wdata_in,
   input wire pop_in,
   output reg [7:0] rdata_out,
   output wire full_out,
   output wire empty_out
);
`include "spmf_map.vh"

   reg [7:0] mem_r [0:3];
   reg [1:0] wptr_r;
   reg [1:0] rptr_r;
   reg [2:0] count_r;
   wire do_push;
   wire do_pop;

   assign full_out = (count_r == `SPMF_FIFO_DEPTH);
   assign empty_out = (count_r == 3'h0);
   assign do_push = push_in & ~full_out;
   assign do_pop = pop_in & ~empty_out;

   always @(posedge clk_in) begin
      if (do_push) begin
         mem_r[wptr_r] <= wdata_in;
      end
   end

   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wptr_r <= 2'h0;
         rptr_r <= 2'h0;
         count_r <= 3'h0;
         rdata_out <= 8'h00;
      end else if (clr_in) begin
         wptr_r <= 2'h0;
         rptr_r <= 2'h0;
         count_r <= 3'h0;
      end else begin
         if (do_push) begin
            wptr_r <= wptr_r + 2'h1;
         end
         if (do_pop) begin
            rptr_r <= rptr_r + 2'h1;
            rdata_out <= mem_r[rptr_r];
         end
         if (do_push & ~do_pop) begin
            count_r <= count_r + 3'h1;
         end else if (do_pop & ~do_push) begin
            count_r <= count_r - 3'h1;
         end
      end
   end
endmodule

/* File: spmf_map.vh */
// Register map, field positions, reset values and timing constants of the serial controller.
`ifndef SPMF_MAP_VH
`define SPMF_MAP_VH

`define SPMF_AW 12
`define SPMF_IDX_CONFIG 10'h0a1
`define SPMF_IDX_MODE 10'h0a2
`define SPMF_IDX_STATUS 10'h0a3
`define SPMF_IDX_DATA 10'h0a4
`define SPMF_IDX_IRQ_STATUS 10'h0a5
`define SPMF_IDX_IRQ_MASK 10'h0a6

`define SPMF_SEL_NONE 3'h0
`define SPMF_SEL_CONFIG 3'h1
`define SPMF_SEL_MODE 3'h2
`define SPMF_SEL_STATUS 3'h3
`define SPMF_SEL_DATA 3'h4
`define SPMF_SEL_IRQ_STATUS 3'h5
`define SPMF_SEL_IRQ_MASK 3'h6

`define SPMF_CFG_IRQ_EN 7
`define SPMF_CFG_ENABLE 6
`define SPMF_CFG_MASTER 5
`define SPMF_CFG_CPOL 4
`define SPMF_CFG_CPHA 3
`define SPMF_CFG_SEDGE 2
`define SPMF_CFG_RESET 8'h20
`define SPMF_CFG_WMASK 8'hfc

`define SPMF_MODE_THR_HI 7
`define SPMF_MODE_THR_LO 6
`define SPMF_MODE_FIFO_CLEAR 5
`define SPMF_MODE_RATE_HI 3
`define SPMF_MODE_RATE_LO 1
`define SPMF_MODE_DIR 0
`define SPMF_MODE_RESET 8'h00
`define SPMF_MODE_WMASK 8'hcf

`define SPMF_ST_RFULL 3
`define SPMF_ST_RX_QUEUE_EMPTY 2
`define SPMF_ST_TFULL 1
`define SPMF_ST_TEMPT 0

`define SPMF_EV_W 3
`define SPMF_EV_THR 0
`define SPMF_EV_ROVR 1
`define SPMF_EV_TOVR 2
`define SPMF_EV_RESET 3'h0

`define SPMF_RESP_OKAY 2'h0
`define SPMF_RESP_DECERR 2'h3

`define SPMF_HALF_6 9'h003
`define SPMF_HALF_8 9'h004
`define SPMF_HALF_16 9'h008
`define SPMF_HALF_32 9'h010
`define SPMF_HALF_64 9'h020
`define SPMF_HALF_128 9'h040
`define SPMF_HALF_256 9'h080
`define SPMF_HALF_512 9'h100

`define SPMF_LAST_BIT 3'h7
`define SPMF_LAST_EDGE 4'hf
`define SPMF_FIFO_DEPTH 3'h4

`endif

/* File: spmf_monitor.sv */
// Port-level checker for the serial controller: bus handshakes and pin timing.
module spmf_monitor (
   input wire logic CLK_IN,
   input wire logic RSTN_IN,
   input wire logic AXI_AWVALID_IN,
   input wire logic AXI_AWREADY_OUT,
   input wire logic AXI_WVALID_IN,
   input wire logic AXI_WREADY_OUT,
   input wire logic [1:0] AXI_BRESP_OUT,
   input wire logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   input wire logic AXI_ARVALID_IN,
   input wire logic AXI_ARREADY_OUT,
   input wire logic [31:0] AXI_RDATA_OUT,
   input wire logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   input wire logic MOSI_OE_OUT,
   input wire logic MISO_OE_OUT,
   input wire logic SCK_OUT,
   input wire logic SCK_OE_OUT,
   input wire logic SLAVE_SELECT_N_IN
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RSTN_IN);
   sequence s_ar_take;
      AXI_ARVALID_IN && AXI_ARREADY_OUT;
   endsequence
   sequence s_w_take;
      AXI_AWVALID_IN && AXI_AWREADY_OUT && AXI_WVALID_IN && AXI_WREADY_OUT && !AXI_BVALID_OUT;
   endsequence
   sequence s_sck_edge;
      SCK_OE_OUT && $changed(SCK_OUT);
   endsequence
   chk_bresp_hold:
   assert property (AXI_BVALID_OUT && !AXI_BREADY_IN |=> AXI_BVALID_OUT && $stable(AXI_BRESP_OUT))
      else $error("write response dropped or changed before it was accepted");
   chk_rdata_hold:
   assert property (AXI_RVALID_OUT && !AXI_RREADY_IN |=> AXI_RVALID_OUT && $stable(AXI_RDATA_OUT))
      else $error("read data dropped or changed before it was accepted");
   chk_read_latency:
   assert property (s_ar_take |-> !AXI_RVALID_OUT ##[1:3] AXI_RVALID_OUT)
      else $error("read answer late or early");
   chk_write_latency:
   assert property (s_w_take |-> ##[1:2] AXI_BVALID_OUT)
      else $error("write answer late");
   chk_aw_refuse:
   assert property (AXI_AWVALID_IN && AXI_AWREADY_OUT |=> !AXI_AWREADY_OUT)
      else $error("second write address taken while one is held");
   chk_role_excl:
   assert property (!(MISO_OE_OUT && SCK_OE_OUT))
      else $error("master and slave drivers on together");
   chk_select_idle:
   assert property (SLAVE_SELECT_N_IN [*3] |-> !MISO_OE_OUT)
      else $error("slave data driven while deselected");
   chk_miso_release:
   assert property ($rose(SLAVE_SELECT_N_IN) |=> !MISO_OE_OUT)
      else $error("slave data driver not released one clock after deselect");
   chk_pins_paired:
   assert property (SCK_OE_OUT == MOSI_OE_OUT)
      else $error("serial clock and master data drivers disagree");
   chk_sck_half:
   assert property (s_sck_edge |=> $stable(SCK_OUT) [*2])
      else $error("serial clock half period shorter than three clocks");
endmodule
bind spmf_top spmf_monitor spmf_monitor_inst (.*);

/* File: spmf_peer.sv */
// Behavioural serial peripheral answering the controller while it is master.
module spmf_peer (
   input wire logic sck_in,
   input wire logic sel_in,
   input wire logic mosi_in,
   input wire logic cpol_in,
   input wire logic msb_in,
   input wire logic [7:0] first_in,
   output logic miso_out,
   output logic [7:0] got_out,
   output logic done_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh_r;
   logic [7:0] rx_r;
   int n_r = 0;
   initial done_out = 1'h0;
   initial miso_out = 1'h0;
   always @(posedge sel_in) begin
      n_r = 0;
      sh_r = first_in;
      miso_out = msb_in ? sh_r[7] : sh_r[0];
   end
   // A released line shows the inverse of its last level, never a stale bit.
   always @(negedge sel_in) miso_out = ~miso_out;
   // Leading edges sample, trailing edges shift; the first reply is first_in, each later one the inverse of the last byte.
   always @(sck_in) begin
      if (sel_in && (sck_in ^ cpol_in)) begin
         rx_r = msb_in ? {rx_r[6:0], mosi_in} : {mosi_in, rx_r[7:1]};
         n_r++;
         if (n_r == 8) begin
            got_out = rx_r;
            done_out = ~done_out;
         end
      end else if (sel_in && n_r > 0) begin
         if (n_r == 8) begin
            n_r = 0;
            sh_r = ~rx_r;
         end else begin
            sh_r = msb_in ? sh_r << 1 : sh_r >> 1;
         end
         miso_out = msb_in ? sh_r[7] : sh_r[0];
      end
   end
endmodule

/* File: spmf_top.v */
// Serial master/slave controller with byte queues and an AXI4-Lite register slave.
`include "spmf_map.vh"

// How it works
// - Separate four-byte transmit and receive queues buffer the serial bytes.
// - Link uses data out, data in, master-driven clock and slave select.
// - Active-low slave select matters only in slave mode, ignored as master.
// - Master samples on rising clock edge if sample-edge bit set, else falling.
// - Slave samples rising, shifts falling when CPOL equals CPHA; otherwise reversed.
// - Threshold field raises the transfer event after one to four bytes.
// - Writing one to the clear bit empties both queues.
// - Rate code selects master clock divide by 6 up to 512.
// - Bit-order bit one shifts MSB first, zero shifts LSB first.
// - Data port read pops receive queue, write pushes transmit queue.
// - Read-only full and empty flags for both queues.
module spmf_top (
   input wire CLK_IN,
   input wire RSTN_IN,
   input wire [`SPMF_AW-1:0] AXI_AWADDR_IN,
   input wire AXI_AWVALID_IN,
   output wire AXI_AWREADY_OUT,
   input wire [31:0] AXI_WDATA_IN,
   input wire [3:0] AXI_WSTRB_IN,
   input wire AXI_WVALID_IN,
   output wire AXI_WREADY_OUT,
   output reg [1:0] AXI_BRESP_OUT,
   output reg AXI_BVALID_OUT,
   input wire AXI_BREADY_IN,
   input wire [`SPMF_AW-1:0] AXI_ARADDR_IN,
   input wire AXI_ARVALID_IN,
   output wire AXI_ARREADY_OUT,
   output reg [31:0] AXI_RDATA_OUT,
   output reg [1:0] AXI_RRESP_OUT,
   output reg AXI_RVALID_OUT,
   input wire AXI_RREADY_IN,
   input wire MOSI_IN,
   output reg MOSI_OUT,
   output reg MOSI_OE_OUT,
   input wire MISO_IN,
   output reg MISO_OUT,
   output reg MISO_OE_OUT,
   input wire SCK_IN,
   output reg SCK_OUT,
   output reg SCK_OE_OUT,
   input wire SLAVE_SELECT_N_IN,
   output wire IRQ_OUT
);

   localparam ST_IDLE = 2'h0;
   localparam ST_POP = 2'h1;
   localparam ST_LOAD = 2'h2;
   localparam ST_RUN = 2'h3;

   // Maps a byte address onto a register select code.
   function [2:0] reg_sel;
      input [`SPMF_AW-1:0] addr;
      begin
         case (addr[`SPMF_AW-1:2])
            `SPMF_IDX_CONFIG: reg_sel = `SPMF_SEL_CONFIG;
            `SPMF_IDX_MODE: reg_sel = `SPMF_SEL_MODE;
            `SPMF_IDX_STATUS: reg_sel = `SPMF_SEL_STATUS;
            `SPMF_IDX_DATA: reg_sel = `SPMF_SEL_DATA;
            `SPMF_IDX_IRQ_STATUS: reg_sel = `SPMF_SEL_IRQ_STATUS;
            `SPMF_IDX_IRQ_MASK: reg_sel = `SPMF_SEL_IRQ_MASK;
            default: reg_sel = `SPMF_SEL_NONE;
         endcase
      end
   endfunction

   // Half period of the master clock in system clocks for each rate code.
   function [8:0] half_count;
      input [2:0] code;
      begin
         case (code)
            3'h0: half_count = `SPMF_HALF_6;
            3'h1: half_count = `SPMF_HALF_8;
            3'h2: half_count = `SPMF_HALF_16;
            3'h3: half_count = `SPMF_HALF_32;
            3'h4: half_count = `SPMF_HALF_64;
            3'h5: half_count = `SPMF_HALF_128;
            3'h6: half_count = `SPMF_HALF_256;
            default: half_count = `SPMF_HALF_512;
         endcase
      end
   endfunction

   reg [7:0] cfg_r;
   reg [7:0] mode_r;
   reg [`SPMF_EV_W-1:0] ev_r;
   reg [`SPMF_EV_W-1:0] ev_mask_r;
   reg aw_got_r;
   reg w_got_r;
   reg [`SPMF_AW-1:0] awaddr_r;
   reg [7:0] wbyte_r;
   reg wlane_r;
   reg rd_pend_r;
   reg [2:0] rsel_r;
   reg [1:0] state_r;
   reg [8:0] half_r;
   reg [3:0] edge_cnt_r;
   reg [2:0] bit_cnt_r;
   reg sampled_r;
   reg had_byte_r;
   reg [7:0] tx_sr_r;
   reg [7:0] rx_sr_r;
   reg sck_prev_r;
   reg [2:0] byte_cnt_r;
   reg [`SPMF_EV_W-1:0] ev_set;
   reg [`SPMF_EV_W-1:0] ev_nxt;

   wire enable = cfg_r[`SPMF_CFG_ENABLE];
   wire master = cfg_r[`SPMF_CFG_MASTER];
   wire cpol = cfg_r[`SPMF_CFG_CPOL];
   wire cpha = cfg_r[`SPMF_CFG_CPHA];
   wire msb_first = mode_r[`SPMF_MODE_DIR];
   wire [1:0] thr = mode_r[`SPMF_MODE_THR_HI:`SPMF_MODE_THR_LO];
   wire [2:0] rate = mode_r[`SPMF_MODE_RATE_HI:`SPMF_MODE_RATE_LO];
   wire run_master = enable & master;
   wire run_slave = enable & ~master & ~SLAVE_SELECT_N_IN;
   wire wr_go = aw_got_r & w_got_r & ~AXI_BVALID_OUT;
   wire [2:0] wsel = reg_sel(awaddr_r);
   wire ar_go = AXI_ARVALID_IN & AXI_ARREADY_OUT;
   wire [2:0] asel = reg_sel(AXI_ARADDR_IN);
   wire fifo_clr = wr_go & wlane_r & (wsel == `SPMF_SEL_MODE) & wbyte_r[`SPMF_MODE_FIFO_CLEAR];
   wire [7:0] tx_head;
   wire [7:0] rx_head;
   wire tx_full;
   wire tx_empty;
   wire rx_full;
   wire rx_empty;
   wire tx_push = wr_go & wlane_r & (wsel == `SPMF_SEL_DATA);
   wire rx_pop = ar_go & (asel == `SPMF_SEL_DATA);
   wire tx_pop = (state_r == ST_POP);
   wire half_done = (half_r == 9'h000);
   wire m_edge = run_master & (state_r == ST_RUN) & half_done;
   wire s_edge = run_slave & (state_r == ST_RUN) & (SCK_IN != sck_prev_r);
   wire any_edge = m_edge | s_edge;
   wire edge_rise = master ? ~SCK_OUT : SCK_IN;
   wire samp_on_rise = master ? cfg_r[`SPMF_CFG_SEDGE] : (cpol == cpha);
   wire serial_in = master ? MISO_IN : MOSI_IN;
   wire do_sample = any_edge & (edge_rise == samp_on_rise);
   wire do_shift = any_edge & (edge_rise != samp_on_rise) & sampled_r;
   wire byte_done = do_sample & (bit_cnt_r == `SPMF_LAST_BIT);
   wire [7:0] rx_byte = msb_first ? {rx_sr_r[6:0], serial_in} : {serial_in, rx_sr_r[7:1]};
   wire [7:0] load_byte = had_byte_r ? tx_head : 8'h00;

   spmf_fifo u_tx_fifo (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .clr_in(fifo_clr),
      .push_in(tx_push),
      .wdata_in(wbyte_r),
      .pop_in(tx_pop),
      .rdata_out(tx_head),
      .full_out(tx_full),
      .empty_out(tx_empty)
   );

   spmf_fifo u_rx_fifo (
      .clk_in(CLK_IN),
      .rstn_in(RSTN_IN),
      .clr_in(fifo_clr),
      .push_in(byte_done),
      .wdata_in(rx_byte),
      .pop_in(rx_pop),
      .rdata_out(rx_head),
      .full_out(rx_full),
      .empty_out(rx_empty)
   );

   assign AXI_AWREADY_OUT = ~aw_got_r;
   assign AXI_WREADY_OUT = ~w_got_r;
   assign AXI_ARREADY_OUT = ~rd_pend_r & ~AXI_RVALID_OUT;
   assign IRQ_OUT = cfg_r[`SPMF_CFG_IRQ_EN] & (|(ev_r & ev_mask_r));

   // Write side: address and data are taken independently, the write happens once both are held.
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         aw_got_r <= 1'b0;
         w_got_r <= 1'b0;
         awaddr_r <= {`SPMF_AW{1'b0}};
         wbyte_r <= 8'h00;
         wlane_r <= 1'b0;
         AXI_BVALID_OUT <= 1'b0;
         AXI_BRESP_OUT <= `SPMF_RESP_OKAY;
         cfg_r <= `SPMF_CFG_RESET;
         mode_r <= `SPMF_MODE_RESET;
         ev_mask_r <= `SPMF_EV_RESET;
      end else begin
         if (AXI_AWVALID_IN & ~aw_got_r) begin
            aw_got_r <= 1'b1;
            awaddr_r <= AXI_AWADDR_IN;
         end
         if (AXI_WVALID_IN & ~w_got_r) begin
            w_got_r <= 1'b1;
            wbyte_r <= AXI_WDATA_IN[7:0];
            wlane_r <= AXI_WSTRB_IN[0];
         end
         if (wr_go) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            AXI_BVALID_OUT <= 1'b1;
            AXI_BRESP_OUT <= (wsel == `SPMF_SEL_NONE) ? `SPMF_RESP_DECERR : `SPMF_RESP_OKAY;
            if (wlane_r) begin
               case (wsel)
                  `SPMF_SEL_CONFIG: cfg_r <= wbyte_r & `SPMF_CFG_WMASK;
                  `SPMF_SEL_MODE: mode_r <= wbyte_r & `SPMF_MODE_WMASK;
                  `SPMF_SEL_IRQ_MASK: ev_mask_r <= wbyte_r[`SPMF_EV_W-1:0];
                  default: ev_mask_r <= ev_mask_r;
               endcase
            end
         end else if (AXI_BVALID_OUT & AXI_BREADY_IN) begin
            AXI_BVALID_OUT <= 1'b0;
         end
      end
   end

   // Read side: the data port pops the receive queue, whose head register is valid next cycle.
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         rd_pend_r <= 1'b0;
         rsel_r <= `SPMF_SEL_NONE;
         AXI_RVALID_OUT <= 1'b0;
         AXI_RDATA_OUT <= 32'h00000000;
         AXI_RRESP_OUT <= `SPMF_RESP_OKAY;
      end else begin
         rd_pend_r <= ar_go;
         if (ar_go) begin
            rsel_r <= asel;
         end
         if (rd_pend_r) begin
            AXI_RVALID_OUT <= 1'b1;
            AXI_RRESP_OUT <= (rsel_r == `SPMF_SEL_NONE) ? `SPMF_RESP_DECERR : `SPMF_RESP_OKAY;
            case (rsel_r)
               `SPMF_SEL_CONFIG: AXI_RDATA_OUT <= {24'h000000, cfg_r};
               `SPMF_SEL_MODE: AXI_RDATA_OUT <= {24'h000000, mode_r};
               `SPMF_SEL_STATUS: AXI_RDATA_OUT <= {28'h0000000, rx_full, rx_empty,
                                                   tx_full, tx_empty};
               `SPMF_SEL_DATA: AXI_RDATA_OUT <= {24'h000000, rx_head};
               `SPMF_SEL_IRQ_STATUS: AXI_RDATA_OUT <= {29'h00000000, ev_r};
               `SPMF_SEL_IRQ_MASK: AXI_RDATA_OUT <= {29'h00000000, ev_mask_r};
               default: AXI_RDATA_OUT <= 32'h00000000;
            endcase
         end else if (AXI_RVALID_OUT & AXI_RREADY_IN) begin
            AXI_RVALID_OUT <= 1'b0;
         end
      end
   end

   // Sticky events; a new event in the cycle of its write-one clear stays set.
   always @* begin
      ev_set = `SPMF_EV_RESET;
      ev_set[`SPMF_EV_THR] = byte_done & (byte_cnt_r == {1'b0, thr});
      ev_set[`SPMF_EV_ROVR] = byte_done & rx_full;
      ev_set[`SPMF_EV_TOVR] = tx_push & tx_full;
      ev_nxt = ev_r;
      if (wr_go & wlane_r & (wsel == `SPMF_SEL_IRQ_STATUS)) begin
         ev_nxt = ev_r & ~wbyte_r[`SPMF_EV_W-1:0];
      end
      ev_nxt = ev_nxt | ev_set;
   end

   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         ev_r <= `SPMF_EV_RESET;
         byte_cnt_r <= 3'h0;
      end else begin
         ev_r <= ev_nxt;
         if (fifo_clr | ~enable) begin
            byte_cnt_r <= 3'h0;
         end else if (byte_done) begin
            byte_cnt_r <= (byte_cnt_r == {1'b0, thr}) ? 3'h0 : byte_cnt_r + 3'h1;
         end
      end
   end

   // Serial engine shared by master and slave.
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         state_r <= ST_IDLE;
         half_r <= 9'h000;
         edge_cnt_r <= 4'h0;
         bit_cnt_r <= 3'h0;
         sampled_r <= 1'b0;
         had_byte_r <= 1'b0;
         tx_sr_r <= 8'h00;
         rx_sr_r <= 8'h00;
         sck_prev_r <= 1'b0;
         SCK_OUT <= 1'b0;
         MOSI_OUT <= 1'b0;
         MISO_OUT <= 1'b0;
      end else begin
         sck_prev_r <= SCK_IN;
         case (state_r)
            ST_IDLE: begin
               SCK_OUT <= cpol;
               if (run_master & ~tx_empty) begin
                  state_r <= ST_POP;
               end else if (run_slave) begin
                  state_r <= ST_POP;
               end
            end
            ST_POP: begin
               had_byte_r <= ~tx_empty;
               state_r <= ST_LOAD;
            end
            ST_LOAD: begin
               tx_sr_r <= load_byte;
               MOSI_OUT <= msb_first ? load_byte[7] : load_byte[0];
               MISO_OUT <= msb_first ? load_byte[7] : load_byte[0];
               half_r <= half_count(rate) - 9'h001;
               edge_cnt_r <= 4'h0;
               bit_cnt_r <= 3'h0;
               sampled_r <= 1'b0;
               state_r <= ST_RUN;
            end
            ST_RUN: begin
               if (m_edge) begin
                  SCK_OUT <= ~SCK_OUT;
                  half_r <= half_count(rate) - 9'h001;
                  edge_cnt_r <= edge_cnt_r + 4'h1;
                  if (edge_cnt_r == `SPMF_LAST_EDGE) begin
                     state_r <= ST_IDLE;
                  end
               end else if (run_master) begin
                  half_r <= half_r - 9'h001;
               end
               if (do_sample) begin
                  // Master takes the edge chosen by the sample-edge bit, slave the CPOL/CPHA one.
                  rx_sr_r <= rx_byte;
                  sampled_r <= 1'b1;
                  bit_cnt_r <= bit_cnt_r + 3'h1;
                  if (byte_done & run_slave) begin
                     state_r <= ST_POP;
                  end
               end
               if (do_shift) begin
                  tx_sr_r <= msb_first ? {tx_sr_r[6:0], 1'b0} : {1'b0, tx_sr_r[7:1]};
                  MOSI_OUT <= msb_first ? tx_sr_r[6] : tx_sr_r[1];
                  MISO_OUT <= msb_first ? tx_sr_r[6] : tx_sr_r[1];
               end
               if (~run_master & ~run_slave) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
         if (fifo_clr) begin
            state_r <= ST_IDLE;
         end
      end
   end

   // Pin drivers: the master owns clock and data out, a selected slave owns its data out.
   always @(posedge CLK_IN or negedge RSTN_IN) begin
      if (!RSTN_IN) begin
         SCK_OE_OUT <= 1'b0;
         MOSI_OE_OUT <= 1'b0;
         MISO_OE_OUT <= 1'b0;
      end else begin
         SCK_OE_OUT <= run_master;
         MOSI_OE_OUT <= run_master;
         MISO_OE_OUT <= run_slave;
      end
   end
endmodule

/* File: tb_top.sv */
// Self-checking bench: registers, queues, interrupt and master transfers of the controller.
`include "spmf_map.vh"
`define CMP(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] A_CFG = {`SPMF_IDX_CONFIG, 2'h0};
   localparam logic [11:0] A_MODE = {`SPMF_IDX_MODE, 2'h0};
   localparam logic [11:0] A_ST = {`SPMF_IDX_STATUS, 2'h0};
   localparam logic [11:0] A_DATA = {`SPMF_IDX_DATA, 2'h0};
   localparam logic [11:0] A_IRQS = {`SPMF_IDX_IRQ_STATUS, 2'h0};
   localparam logic [11:0] A_IRQM = {`SPMF_IDX_IRQ_MASK, 2'h0};
   logic CLK_IN = 1'h0, RSTN_IN = 1'h0, SLAVE_SELECT_N_IN = 1'h1;
   logic AXI_AWVALID_IN = 1'h0, AXI_WVALID_IN = 1'h0, AXI_BREADY_IN = 1'h0;
   logic AXI_ARVALID_IN = 1'h0, AXI_RREADY_IN = 1'h0;
   logic [11:0] AXI_AWADDR_IN = 12'h000, AXI_ARADDR_IN = 12'h000;
   logic [31:0] AXI_WDATA_IN = 32'h0;
   logic [3:0] AXI_WSTRB_IN = 4'h1;
   wire AXI_AWREADY_OUT, AXI_WREADY_OUT, AXI_BVALID_OUT, AXI_ARREADY_OUT, AXI_RVALID_OUT;
   wire [1:0] AXI_BRESP_OUT, AXI_RRESP_OUT;
   wire [31:0] AXI_RDATA_OUT;
   wire MOSI_OUT, MOSI_OE_OUT, MISO_OUT, MISO_OE_OUT, SCK_OUT, SCK_OE_OUT, IRQ_OUT;
   wire MOSI_IN, MISO_IN, SCK_IN, peer_miso, done;
   wire [7:0] got;
   logic cpol = 1'h0, msb = 1'h0, sck_q = 1'h0, sck_tb = 1'h0, mosi_tb = 1'h0;
   logic [7:0] first = 8'h00, el;
   logic [33:0] er;
   logic [1:0] eb;
   logic [33:0] exp_rd[$];
   logic [1:0] exp_b[$];
   logic [7:0] exp_lk[$];
   int err_total = 0, n_compared = 0, cyc = 0, seed = 67104, ln = 0, half_ns = 0;
   time t_last = 0;
   assign SCK_IN = SCK_OE_OUT ? SCK_OUT : sck_tb;
   assign MOSI_IN = MOSI_OE_OUT ? MOSI_OUT : mosi_tb;
   assign MISO_IN = MISO_OE_OUT ? MISO_OUT : peer_miso;
   spmf_top spmf_top_inst (.*);
   spmf_peer spmf_peer_inst (.sck_in(SCK_OUT), .sel_in(SCK_OE_OUT), .mosi_in(MOSI_OUT),
      .cpol_in(cpol), .msb_in(msb), .first_in(first), .miso_out(peer_miso),
      .got_out(got), .done_out(done));
   always #10 CLK_IN = ~CLK_IN;
   task automatic print_verdict();
      $display("compared=%0d mismatches=%0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge CLK_IN) begin
      cyc++;
      if (cyc == 80000) begin
         err_total++;
         print_verdict();
      end
   end
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
      logic ta, tw, v;
      exp_b.push_back(r);
      @(posedge CLK_IN);
      AXI_AWADDR_IN <= a;
      AXI_WDATA_IN <= {24'h000000, d};
      AXI_AWVALID_IN <= 1'h1;
      AXI_WVALID_IN <= 1'h1;
      AXI_BREADY_IN <= 1'h1;
      do begin
         @(negedge CLK_IN);
         ta = AXI_AWVALID_IN && AXI_AWREADY_OUT;
         tw = AXI_WVALID_IN && AXI_WREADY_OUT;
         v = AXI_BVALID_OUT;
         @(posedge CLK_IN);
         if (ta) AXI_AWVALID_IN <= 1'h0;
         if (tw) AXI_WVALID_IN <= 1'h0;
      end while (v !== 1'h1);
      AXI_BREADY_IN <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
      logic t, v;
      exp_rd.push_back({r, 24'h000000, e});
      @(posedge CLK_IN);
      AXI_ARADDR_IN <= a;
      AXI_ARVALID_IN <= 1'h1;
      AXI_RREADY_IN <= 1'h1;
      do begin
         @(negedge CLK_IN);
         t = AXI_ARVALID_IN && AXI_ARREADY_OUT;
         v = AXI_RVALID_OUT;
         @(posedge CLK_IN);
         if (t) AXI_ARVALID_IN <= 1'h0;
      end while (v !== 1'h1);
      AXI_RREADY_IN <= 1'h0;
   endtask
   // Responses are taken off the queues at the negedge before their handshake edge.
   always @(negedge CLK_IN) begin
      if (AXI_RVALID_OUT === 1'h1 && AXI_RREADY_IN) begin
         er = exp_rd.pop_front();
         `CMP({AXI_RRESP_OUT, AXI_RDATA_OUT}, er)
      end
      if (AXI_BVALID_OUT === 1'h1 && AXI_BREADY_IN) begin
         eb = exp_b.pop_front();
         `CMP(AXI_BRESP_OUT, eb)
      end
   end
   always @(done) if (RSTN_IN) begin
      el = exp_lk.pop_front();
      `CMP(got, el)
   end
   // The gap before each byte's first leading edge is not a half period, so it is skipped.
   // Edges are seen at the falling clock edge, once driver enable and clock have settled together.
   always @(negedge CLK_IN) begin
      if (SCK_OE_OUT !== 1'h1) begin
         ln = 0;
      end else if (SCK_OUT !== sck_q && SCK_OUT !== cpol) begin
         if (ln % 8 != 0) `CMP($time - t_last, half_ns)
         ln++;
         t_last = $time;
      end else if (SCK_OUT !== sck_q && ln > 0) begin
         `CMP($time - t_last, half_ns)
         t_last = $time;
      end
      sck_q = SCK_OUT;
   end
   initial begin
      logic [7:0] b, prev;
      logic [7:0] rxe[4];
      logic [2:0] rc;
      logic [1:0] kk;
      logic [7:0] c;
      logic ph;
      repeat (2) @(posedge CLK_IN);
      RSTN_IN <= 1'h1;
      rd(A_CFG, 8'h20, 2'h0);
      rd(A_MODE, 8'h00, 2'h0);
      rd(A_ST, 8'h05, 2'h0);
      rd(12'h100, 8'h00, 2'h3);
      wr(12'h100, 8'h55, 2'h3);
      wr(A_CFG, 8'hff, 2'h0);
      rd(A_CFG, 8'hfc, 2'h0);
      wr(A_CFG, 8'h00, 2'h0);
      wr(A_MODE, 8'hff, 2'h0);
      rd(A_MODE, 8'hcf, 2'h0);
      wr(A_MODE, 8'h00, 2'h0);
      for (int i = 0; i < 5; i++) wr(A_DATA, 8'(i), 2'h0);
      rd(A_ST, 8'h06, 2'h0);
      rd(A_IRQS, 8'h04, 2'h0);
      @(negedge CLK_IN) `CMP(IRQ_OUT, 1'h0)
      wr(A_IRQM, 8'h04, 2'h0);
      wr(A_CFG, 8'h80, 2'h0);
      @(negedge CLK_IN) `CMP(IRQ_OUT, 1'h1)
      wr(A_IRQS, 8'h04, 2'h0);
      @(negedge CLK_IN) `CMP(IRQ_OUT, 1'h0)
      wr(A_MODE, 8'h20, 2'h0);
      rd(A_ST, 8'h05, 2'h0);
      for (int n = 0; n < 8; n++) begin
         rc = 3'(n);
         kk = 2'(n % 4);
         cpol = rc[0];
         msb = rc[1];
         half_ns = (n == 0 ? 6 : 8 << (n - 1)) * 10;
         first = 8'($random(seed));
         prev = first;
         wr(A_MODE, {kk, 2'h0, rc, msb}, 2'h0);
         SLAVE_SELECT_N_IN <= rc[2];
         for (int j = 0; j <= kk; j++) begin
            b = 8'($random(seed));
            rxe[j] = (j == 0) ? first : ~prev;
            prev = b;
            exp_lk.push_back(b);
            wr(A_DATA, b, 2'h0);
         end
         wr(A_IRQM, 8'h01, 2'h0);
         wr(A_CFG, {3'h7, cpol, 1'h0, ~cpol, 2'h0}, 2'h0);
         while (IRQ_OUT !== 1'h1) @(posedge CLK_IN);
         #(2 * half_ns);
         @(negedge CLK_IN) `CMP(SCK_OUT, cpol)
         `CMP(exp_lk.size(), 0)
         rd(A_ST, kk == 2'h3 ? 8'h09 : 8'h01, 2'h0);
         for (int j = 0; j <= kk; j++) rd(A_DATA, rxe[j], 2'h0);
         rd(A_ST, 8'h05, 2'h0);
         wr(A_IRQS, 8'h01, 2'h0);
         wr(A_CFG, 8'h00, 2'h0);
      end
      // Slave runs: phase 0 samples on rising edges, phase 1 on falling edges.
      for (int p = 0; p < 2; p++) begin
         ph = p[0];
         b = 8'($random(seed));
         c = 8'($random(seed));
         wr(A_MODE, {7'h00, ph}, 2'h0);
         wr(A_DATA, b, 2'h0);
         wr(A_CFG, {4'hc, ph, 3'h0}, 2'h0);
         SLAVE_SELECT_N_IN <= 1'h0;
         repeat (4) @(posedge CLK_IN);
         `CMP(MISO_OE_OUT, 1'h1)
         for (int k = 0; k < 8; k++) begin
            rc = 3'(ph ? 7 - k : k);
            mosi_tb <= c[rc];
            repeat (2) @(posedge CLK_IN);
            if (!ph) `CMP(MISO_OUT, b[rc])
            sck_tb <= 1'h1;
            repeat (4) @(posedge CLK_IN);
            if (ph) `CMP(MISO_OUT, b[rc])
            sck_tb <= 1'h0;
            repeat (2) @(posedge CLK_IN);
         end
         SLAVE_SELECT_N_IN <= 1'h1;
         repeat (3) @(posedge CLK_IN);
         `CMP(MISO_OE_OUT, 1'h0)
         `CMP(IRQ_OUT, 1'h1)
         rd(A_DATA, c, 2'h0);
         wr(A_IRQS, 8'h01, 2'h0);
         wr(A_CFG, 8'h00, 2'h0);
      end
      print_verdict();
   end
endmodule
